// [verilog/lpc_pkg.sv]
// constants for the sleep-mode polling configuration register bank
package lpc_pkg;
  localparam int          FRAME_BITS    = 32;
  localparam int          ADDR_MSB      = 31;
  localparam int          ADDR_LSB      = 25;
  localparam int          RW_BIT        = 24;
  localparam int          DATA_MSB      = 23;
  localparam int          FAULT_BIT     = 23;
  localparam int          INTERRUPT_FLAG_BIT_BIT    = 22;
  localparam int          RDATA_MSB     = 21;
  localparam logic [6:0]  ADDR_PCUR_SP  = 7'h16;
  localparam logic [6:0]  ADDR_PCUR_SG  = 7'h17;
  localparam logic [6:0]  ADDR_SLOW_SP  = 7'h18;
  localparam int          NUM_SP        = 8;
  localparam int          NUM_SG        = 14;
  localparam logic [23:0] RESET_VALUE   = 24'h000000;
  localparam int          SLOW_FACTOR   = 4;
  // normal sleep polling currents, in microamps
  localparam int          IPOLL_SB_UA   = 2200;
  localparam int          IPOLL_SG_UA   = 1000;
  typedef enum logic [1:0] {
    LPC_SRC_NORMAL_SB = 2'b00,
    LPC_SRC_NORMAL_SG = 2'b01,
    LPC_SRC_WETTING   = 2'b10
  } lpc_src_type;
endpackage

// [verilog/lpc_cfg_reg.sv]
// one configuration register with write strobe and registered read
`timescale 1ns/1ps
`default_nettype none
module lpc_cfg_reg
  import lpc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic             i_we,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_q
);
  initial begin
    if (WIDTH < 1 || WIDTH > 22) $error("lpc_cfg_reg: WIDTH out of range");
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_q <= RESET_VALUE[WIDTH-1:0];
    end else if (i_we) begin
      o_q <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// [verilog/lpc_poll_cfg.sv]
// sleep-mode polling current and slow polling configuration registers
// Summary of operation
// R01 - 32-bit frame: address, read/write, data
// R02 - programmable-input current select at 0x16
// R03 - zero bit gives normal 2.2/1.0 mA
// R04 - one bit uses programmed wetting current
// R05 - ground-input current select at 0x17
// R06 - ground bit zero 1.0 mA, one wetting
// R07 - programmable-input slow polling at 0x18
// R08 - slow bit polls four times slower
// R09 - reply: fault, interrupt flag, register data
`timescale 1ns/1ps
`default_nettype none
module lpc_poll_cfg
  import lpc_pkg::*;
#(
  parameter int N_SP = NUM_SP,
  parameter int N_SG = NUM_SG
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  input  wire logic                  i_frame_valid,
  input  wire logic [FRAME_BITS-1:0] i_frame,
  input  wire logic                  i_fault_status,
  input  wire logic                  i_interrupt_flag,
  input  wire logic [N_SP-1:0]       i_sp_to_ground,
  input  wire logic                  i_base_poll_tick,
  output logic                       o_reply_valid,
  output logic      [DATA_MSB:0]     o_reply,
  output logic      [2*N_SP-1:0]     o_sp_src,
  output logic      [2*N_SG-1:0]     o_sg_src,
  output logic      [N_SP-1:0]       o_sp_poll_tick,
  output logic      [N_SG-1:0]       o_sg_poll_tick
);
  initial begin
    if (N_SP < 1 || N_SP > 22 || N_SG < 1 || N_SG > 22)
      $error("lpc_poll_cfg: channel count out of range");
  end

  // frame fields
  wire logic [6:0]        frame_addr = i_frame[ADDR_MSB:ADDR_LSB]; // see R01
  wire logic              frame_wr   = i_frame[RW_BIT];
  wire logic [DATA_MSB:0] frame_data = i_frame[DATA_MSB:0];

  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    return a == r;
  endfunction

  wire logic we_pcur_sp = i_frame_valid && frame_wr && hit(frame_addr, ADDR_PCUR_SP); // see R02
  wire logic we_pcur_sg = i_frame_valid && frame_wr && hit(frame_addr, ADDR_PCUR_SG); // see R05
  wire logic we_slow_sp = i_frame_valid && frame_wr && hit(frame_addr, ADDR_SLOW_SP); // see R07

  logic [N_SP-1:0] pcur_sp;
  logic [N_SG-1:0] pcur_sg;
  logic [N_SP-1:0] slow_sp;

  lpc_cfg_reg #(.WIDTH(N_SP)) u_pcur_sp (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_we    (we_pcur_sp),
    .i_wdata (frame_data[N_SP-1:0]),
    .o_q     (pcur_sp)
  );
  lpc_cfg_reg #(.WIDTH(N_SG)) u_pcur_sg (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_we    (we_pcur_sg),
    .i_wdata (frame_data[N_SG-1:0]),
    .o_q     (pcur_sg)
  );
  lpc_cfg_reg #(.WIDTH(N_SP)) u_slow_sp (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_we    (we_slow_sp),
    .i_wdata (frame_data[N_SP-1:0]),
    .o_q     (slow_sp)
  );

  // reply data, taken before any write of the same frame lands
  logic [RDATA_MSB:0] rd_data;
  always_comb begin
    rd_data = '0;
    if (hit(frame_addr, ADDR_PCUR_SP)) rd_data[N_SP-1:0] = pcur_sp;
    else if (hit(frame_addr, ADDR_PCUR_SG)) rd_data[N_SG-1:0] = pcur_sg;
    else if (hit(frame_addr, ADDR_SLOW_SP)) rd_data[N_SP-1:0] = slow_sp;
  end
  wire logic [DATA_MSB:0] reply_d = {i_fault_status, i_interrupt_flag, rd_data}; // see R09

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_reply_valid <= 1'b0;
      o_reply       <= RESET_VALUE;
    end else begin
      o_reply_valid <= i_frame_valid;
      if (i_frame_valid) o_reply <= reply_d; // see R09
    end
  end

  // per-channel current source selection
  lpc_src_type sp_src_d [N_SP];
  lpc_src_type sg_src_d [N_SG];
  logic [N_SP-1:0] sp_tick_d;
  logic [1:0]      slow_cnt_q;
  wire logic       slow_tick = i_base_poll_tick && (slow_cnt_q == 2'(SLOW_FACTOR - 1));

  genvar g;
  generate
    for (g = 0; g < N_SP; g++) begin : g_sp
      assign sp_src_d[g] = pcur_sp[g] ? LPC_SRC_WETTING : // see R04
                           (i_sp_to_ground[g] ? LPC_SRC_NORMAL_SG : LPC_SRC_NORMAL_SB); // see R03
      assign sp_tick_d[g] = slow_sp[g] ? slow_tick : i_base_poll_tick; // see R08
      always_ff @(posedge i_mclk) begin
        if (i_reset) o_sp_src[2*g+:2] <= LPC_SRC_NORMAL_SB;
        else o_sp_src[2*g+:2] <= sp_src_d[g];
      end
    end
    for (g = 0; g < N_SG; g++) begin : g_sg
      assign sg_src_d[g] = pcur_sg[g] ? LPC_SRC_WETTING : LPC_SRC_NORMAL_SG; // see R06
      always_ff @(posedge i_mclk) begin
        if (i_reset) o_sg_src[2*g+:2] <= LPC_SRC_NORMAL_SG;
        else o_sg_src[2*g+:2] <= sg_src_d[g];
      end
    end
  endgenerate

  // divide base poll ticks by four for slow channels
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      slow_cnt_q     <= 2'h0;
      o_sp_poll_tick <= '0;
      o_sg_poll_tick <= '0;
    end else begin
      if (i_base_poll_tick) slow_cnt_q <= slow_cnt_q + 2'h1; // see R08
      o_sp_poll_tick <= sp_tick_d;
      o_sg_poll_tick <= {N_SG{i_base_poll_tick}};
    end
  end
endmodule
`default_nettype wire

// [verif/lpc_host_model.sv]
// host model sending register frames
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model (
  input  wire logic        i_mclk,
  output logic             o_frame_valid,
  output logic      [31:0] o_frame
);
  initial {o_frame_valid, o_frame} = '0;
  task automatic xfer(input logic [31:0] f);
    @(posedge i_mclk) #1;
    {o_frame_valid, o_frame} = {1'b1, f};
    @(posedge i_mclk) #1;
    {o_frame_valid, o_frame} = {1'b0, ~f};
  endtask
endmodule
`default_nettype wire

// [verif/lpc_poll_cfg_asserts.sv]
// port checks for the polling configuration bank
`timescale 1ns/1ps
`default_nettype none
module lpc_poll_cfg_asserts #(parameter int N_SP = 8, N_SG = 14) (
  input wire logic              i_mclk, i_reset, i_frame_valid, o_reply_valid,
  input wire logic [31:0]       i_frame,
  input wire logic [23:0]       o_reply,
  input wire logic [2*N_SP-1:0] o_sp_src,
  input wire logic [2*N_SG-1:0] o_sg_src
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire logic [7:0] op = i_frame_valid ? i_frame[31:24] : 8'h00;
  AST_RVLD: assert property (i_frame_valid |=> o_reply_valid) else $error("late");
  AST_RONE: assert property (!i_frame_valid |=> !o_reply_valid) else $error("extra");
  AST_HOLD: assert property (!i_frame_valid |=> $stable(o_reply)) else $error("held");
  AST_UNMP: assert property (op[7:1] > 7'h18 |=> !o_reply[21:0]) else $error("unmap");
  AST_SPZ: assert property (op[7:1] == 7'h16 |=> !o_reply[21:8]) else $error("spz");
  AST_SGZ: assert property (op[7:1] == 7'h17 |=> !o_reply[21:14]) else $error("sgz");
  AST_SPW: assert property (op == 8'h2d && i_frame[0] |=> ##1 o_sp_src[1:0] == 2'b10)
    else $error("spw");
  AST_SGW: assert property (op == 8'h2f |=> ##1 o_sg_src[27:26] ==
    ($past(i_frame[13], 2) ? 2'b10 : 2'b01)) else $error("sgw");
endmodule
bind lpc_poll_cfg lpc_poll_cfg_asserts #(.N_SP(N_SP), .N_SG(N_SG)) i_chk (.i_mclk, .i_reset,
  .i_frame_valid, .o_reply_valid, .i_frame, .o_reply, .o_sp_src, .o_sg_src);
`default_nettype wire

// [verif/lpc_poll_cfg_bench.sv]
// bench for the polling configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module lpc_poll_cfg_bench;
  logic        i_mclk = 1'b0, i_reset = 1'b1, fv, tk = 1'b0, flt = 1'b1, irq = 1'b0;
  logic [31:0] fr;
  logic [23:0] rp;
  logic [15:0] sps;
  logic [27:0] sgs;
  logic [7:0]  spt, n0 = 8'h0, n1 = 8'h0, n2 = 8'h0;
  logic [13:0] sgt;
  logic        rv;
  int          failures = 0, checks = 0;
  initial forever #2.5 i_mclk = ~i_mclk;
  lpc_poll_cfg i_dut (.i_mclk, .i_reset, .i_frame_valid(fv), .i_frame(fr), .o_reply_valid(rv),
    .i_fault_status(flt), .i_interrupt_flag(irq), .i_sp_to_ground(8'h0f), .i_base_poll_tick(tk),
    .o_reply(rp), .o_sp_src(sps), .o_sg_src(sgs), .o_sp_poll_tick(spt), .o_sg_poll_tick(sgt));
  lpc_host_model i_host (.i_mclk, .o_frame_valid(fv), .o_frame(fr));
  task automatic x(input logic [31:0] f, input logic [21:0] e);
    i_host.xfer(f);
    `CHK("reply_valid", 1'b1, rv)
    `CHK("reply", {flt, irq, e}, rp)
  endtask
  task automatic t_cur;
    x(32'h2dffffa5, 22'h0);
    x(32'h2c000000, 22'ha5);
    `CHK("sp_src", 16'h8866, sps)
    {flt, irq} = 2'b01;
    x(32'h2fffe001, 22'h0);
    x(32'h2e000000, 22'h2001);
    `CHK("sg_src", 28'h9555556, sgs)
    x(32'h33ffffff, 22'h0);
    x(32'h32000000, 22'h0);
    $display("t_cur done");
  endtask
  task automatic t_slow;
    x(32'h31000001, 22'h0);
    x(32'h30000000, 22'h1);
    repeat (16) begin
      tk = ~tk;
      @(posedge i_mclk) #1;
      {n0, n1, n2} = {n0 + spt[0], n1 + spt[1], n2 + sgt[0]};
    end
    `CHK("ticks", 24'h020808, {n0, n1, n2})
    $display("t_slow done");
  endtask
  task automatic t_reset;
    i_reset = 1'b1;
    repeat (2) @(posedge i_mclk);
    #1 i_reset = 1'b0;
    `CHK("rst_reply", 24'h0, rp)
    `CHK("rst_reply_valid", 1'b0, rv)
    `CHK("rst_sp_src", 16'h0, sps)
    `CHK("rst_sg_src", 28'h5555555, sgs)
    x(32'h30000000, 22'h0);
    x(32'h2c000000, 22'h0);
    $display("t_reset done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    #1 i_reset = 1'b0;
    t_cur;
    t_slow;
    t_reset;
    report_and_stop;
  end
  initial begin
    #5000 failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
